// ==== cdr_consts.svh ====
// Offsets, field positions, reset values and write masks of the codec
// output control register slice. Included by both ends of the link.
`ifndef CDR_CONSTS_SVH
`define CDR_CONSTS_SVH

// Device register offsets on the link
`define CDR_OFS_LEFT_AGC_GAIN 8'h20
`define CDR_OFS_RIGHT_AGC_GAIN 8'h21
`define CDR_OFS_LEFT_DEBOUNCE 8'h22
`define CDR_OFS_RIGHT_DEBOUNCE 8'h23
`define CDR_OFS_ADC_FLAGS 8'h24
`define CDR_OFS_DAC_POWER 8'h25
`define CDR_OFS_HP_DRIVER 8'h26
`define CDR_OFS_RESERVED 8'h27
`define CDR_OFS_OUT_STAGE 8'h28
`define CDR_OFS_DAC_SWITCH 8'h29
`define CDR_OFS_POP_REDUCE 8'h2a
`define CDR_OFS_LEFT_DAC_VOL 8'h2b
`define CDR_OFS_RIGHT_DAC_VOL 8'h2c

// Writable bits; all others are reserved or read-only
`define CDR_MASK_DEBOUNCE 8'hff
`define CDR_MASK_DAC_POWER 8'hf0
`define CDR_MASK_HP_DRIVER 8'h3e
`define CDR_MASK_OUT_STAGE 8'hff
`define CDR_MASK_DAC_SWITCH 8'hf3
`define CDR_MASK_POP_REDUCE 8'hfe
`define CDR_MASK_DAC_VOL 8'hff

// Reset values of registers that do not reset to zero
`define CDR_RST_DAC_VOL 8'h80

// Highest AGC gain code, 59.5 dB in half-dB steps
`define CDR_AGC_GAIN_TOP 7'h77

// Host controller registers on AXI4-Lite
`define CDR_AXI_CMD 8'h00
`define CDR_AXI_STATUS 8'h04
`define CDR_CMD_WRITE_BIT 16
`define CDR_STS_BUSY_BIT 0
`define CDR_STS_DONE_BIT 1
`define CDR_AXI_OKAY 2'h0
`define CDR_AXI_SLVERR 2'h2

`endif

// ==== cdr_pkg.sv ====
// Types shared by the device end and the host end of the register link.
// Assumes cdr_consts.svh for the numeric constants.
package cdr_pkg;

    typedef enum logic [1:0] {
        CDR_H_IDLE = 2'b01,
        CDR_H_WAIT = 2'b10
    } cdr_hstate_t;

    typedef struct packed {
        logic [7:0] dbc_l;
        logic [7:0] dbc_r;
        logic [7:0] dac_pwr;
        logic [7:0] hp_drv;
        logic [7:0] out_stage;
        logic [7:0] dac_sw;
        logic [7:0] pop;
        logic [7:0] vol_l;
        logic [7:0] vol_r;
        logic [7:0] gain_l;
        logic [7:0] gain_r;
        logic [7:0] flags;
        logic [7:0] eff_vol_l;
        logic [7:0] eff_vol_r;
        logic [11:0] noise_l;
        logic [11:0] noise_r;
        logic [6:0] sig_l;
        logic [6:0] sig_r;
        logic [18:0] pwron;
        logic [2:0] ramp;
        logic ack;
        logic [7:0] rdata;
    } cdr_dev_st_t;

    typedef struct packed {
        cdr_hstate_t state;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic done;
        logic cmd_we;
        logic [7:0] cmd_addr;
        logic [7:0] cmd_data;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic aw_rdy;
        logic w_rdy;
        logic bvld;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvld;
        logic [31:0] rd;
        logic [1:0] rresp;
    } cdr_host_st_t;

endpackage

// ==== cdr_link_if.sv ====
// Register link between the host controller and the codec register slice.
// Both ends run on the same clock; req is held until ack is seen.
`timescale 1ns/1ps
interface cdr_link_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;

    modport dev (
        input req,
        input we,
        input addr,
        input wdata,
        output ack,
        output rdata
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input ack,
        input rdata
    );
endinterface

// ==== cdr_dev_regs.sv ====
// Codec register slice: AGC gain readback, debounce, ADC/AGC flags, DAC
// power, driver setup, bypass, switching, pop reduction and DAC volume.
// Assumes a host on cdr_link_if that holds req until it sees ack.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "cdr_consts.svh"

module cdr_dev_regs (
    input wire logic MCLK,
    input wire logic RST_B,
    cdr_link_if.dev link,
    input wire logic [7:0] AGC_GAIN_L,
    input wire logic [7:0] AGC_GAIN_R,
    input wire logic [6:0] AGC_MAX_L,
    input wire logic [6:0] AGC_MAX_R,
    input wire logic PGA_MATCH_L,
    input wire logic PGA_MATCH_R,
    input wire logic ADC_UP_L,
    input wire logic ADC_UP_R,
    input wire logic BELOW_NOISE_L,
    input wire logic BELOW_NOISE_R,
    input wire logic DOUBLE_RATE_AUDIO,
    output logic DAC_PWR_L,
    output logic DAC_PWR_R,
    output logic [1:0] LEFT_COMMON_DRV_CFG,
    output logic [2:0] RIGHT_COMMON_DRV_CFG,
    output logic SCP_EN,
    output logic SCP_AUTO_PD,
    output logic [1:0] COMMON_MODE_VOLTAGE_SEL,
    output logic [1:0] BYPASS_L,
    output logic [1:0] BYPASS_R,
    output logic [1:0] SOFT_STEP,
    output logic [1:0] DAC_SWITCH_L,
    output logic [1:0] DAC_SWITCH_R,
    output logic [18:0] PWRON_DELAY_10US,
    output logic [2:0] RAMP_STEP_MS,
    output logic WEAK_CM_BANDGAP,
    output logic MUTE_L,
    output logic MUTE_R,
    output logic [6:0] ATTEN_L,
    output logic [6:0] ATTEN_R,
    output logic [11:0] NOISE_DBC_HALF_MS_L,
    output logic [11:0] NOISE_DBC_HALF_MS_R,
    output logic [6:0] SIG_DBC_HALF_MS_L,
    output logic [6:0] SIG_DBC_HALF_MS_R
);
    import cdr_pkg::*;

    cdr_dev_st_t st_q;
    cdr_dev_st_t st_d;

    // Noise debounce in half-ms units: 0 for code 0, 2^(code-1) for 1 to 7, 128*(code-7) up
    function automatic logic [11:0] noise_dbc(input logic [4:0] code);
        logic [11:0] mult;
        mult = {7'h00, code} - 12'h007;
        if (code == 5'h00) begin
            noise_dbc = 12'h000;
        end else if (code < 5'h08) begin
            noise_dbc = 12'h001 << (code - 5'h01);
        end else begin
            noise_dbc = {mult[4:0], 7'h00};
        end
    endfunction

    function automatic logic [6:0] sig_dbc(input logic [2:0] code);
        if (code == 3'h0) begin
            sig_dbc = 7'h00;
        end else begin
            sig_dbc = 7'h01 << (code - 3'h1);
        end
    endfunction

    // Driver power-on delay in units of 10 us
    function automatic logic [18:0] pwron_delay(input logic [3:0] code);
        case (code)
            4'h0: pwron_delay = 19'h00000;
            4'h1: pwron_delay = 19'h00001;
            4'h2: pwron_delay = 19'h0000a;
            4'h3: pwron_delay = 19'h00064;
            4'h4: pwron_delay = 19'h003e8;
            4'h5: pwron_delay = 19'h01388;
            4'h6: pwron_delay = 19'h02710;
            4'h7: pwron_delay = 19'h04e20;
            4'h8: pwron_delay = 19'h09c40;
            4'h9: pwron_delay = 19'h13880;
            4'ha: pwron_delay = 19'h30d40;
            // Codes above 1011 are forbidden; treat them as the longest
            default: pwron_delay = 19'h61a80;
        endcase
    endfunction

    // Gain codes above 59.5 dB still cap there, so the compare uses the cap
    function automatic logic saturated(input logic [7:0] gain,
                                       input logic [6:0] max);
        logic [6:0] cap;
        cap = (max > `CDR_AGC_GAIN_TOP) ? `CDR_AGC_GAIN_TOP : max;
        saturated = (gain == {1'b0, cap});
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wr,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (wr & mask);
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.ack = 1'b0;

        st_d.gain_l = AGC_GAIN_L;
        st_d.gain_r = AGC_GAIN_R;
        st_d.flags = {PGA_MATCH_L, ADC_UP_L, BELOW_NOISE_L,
                      saturated(AGC_GAIN_L, AGC_MAX_L),
                      PGA_MATCH_R, ADC_UP_R, BELOW_NOISE_R,
                      saturated(AGC_GAIN_R, AGC_MAX_R)};

        // Writes take effect only on writable bits; the access is taken once
        // per request since ack stays high for one cycle only
        if (link.req && !st_q.ack) begin
            st_d.ack = 1'b1;
            if (link.we) begin
                unique case (link.addr)
                    `CDR_OFS_LEFT_DEBOUNCE: st_d.dbc_l = merge(st_q.dbc_l,
                        link.wdata, `CDR_MASK_DEBOUNCE);
                    `CDR_OFS_RIGHT_DEBOUNCE: st_d.dbc_r = merge(st_q.dbc_r,
                        link.wdata, `CDR_MASK_DEBOUNCE);
                    `CDR_OFS_DAC_POWER: st_d.dac_pwr = merge(st_q.dac_pwr,
                        link.wdata, `CDR_MASK_DAC_POWER);
                    `CDR_OFS_HP_DRIVER: st_d.hp_drv = merge(st_q.hp_drv,
                        link.wdata, `CDR_MASK_HP_DRIVER);
                    `CDR_OFS_OUT_STAGE: st_d.out_stage = merge(st_q.out_stage,
                        link.wdata, `CDR_MASK_OUT_STAGE);
                    `CDR_OFS_DAC_SWITCH: st_d.dac_sw = merge(st_q.dac_sw,
                        link.wdata, `CDR_MASK_DAC_SWITCH);
                    `CDR_OFS_POP_REDUCE: st_d.pop = merge(st_q.pop,
                        link.wdata, `CDR_MASK_POP_REDUCE);
                    `CDR_OFS_LEFT_DAC_VOL: st_d.vol_l = merge(st_q.vol_l,
                        link.wdata, `CDR_MASK_DAC_VOL);
                    `CDR_OFS_RIGHT_DAC_VOL: st_d.vol_r = merge(st_q.vol_r,
                        link.wdata, `CDR_MASK_DAC_VOL);
                    // Gain, flag and reserved registers drop writes
                    default: st_d.rdata = st_q.rdata;
                endcase
            end else begin
                unique case (link.addr)
                    `CDR_OFS_LEFT_AGC_GAIN: st_d.rdata = st_q.gain_l;
                    `CDR_OFS_RIGHT_AGC_GAIN: st_d.rdata = st_q.gain_r;
                    `CDR_OFS_LEFT_DEBOUNCE: st_d.rdata = st_q.dbc_l;
                    `CDR_OFS_RIGHT_DEBOUNCE: st_d.rdata = st_q.dbc_r;
                    `CDR_OFS_ADC_FLAGS: st_d.rdata = st_q.flags;
                    `CDR_OFS_DAC_POWER: st_d.rdata = st_q.dac_pwr;
                    `CDR_OFS_HP_DRIVER: st_d.rdata = st_q.hp_drv;
                    `CDR_OFS_OUT_STAGE: st_d.rdata = st_q.out_stage;
                    `CDR_OFS_DAC_SWITCH: st_d.rdata = st_q.dac_sw;
                    `CDR_OFS_POP_REDUCE: st_d.rdata = st_q.pop;
                    `CDR_OFS_LEFT_DAC_VOL: st_d.rdata = st_q.vol_l;
                    `CDR_OFS_RIGHT_DAC_VOL: st_d.rdata = st_q.vol_r;
                    default: st_d.rdata = 8'h00;
                endcase
            end
        end

        // Linkage 01 and 10 borrow the other channel's whole register
        unique case (st_d.dac_sw[1:0])
            2'b01: begin
                st_d.eff_vol_l = st_d.vol_r;
                st_d.eff_vol_r = st_d.vol_r;
            end
            2'b10: begin
                st_d.eff_vol_l = st_d.vol_l;
                st_d.eff_vol_r = st_d.vol_l;
            end
            default: begin
                st_d.eff_vol_l = st_d.vol_l;
                st_d.eff_vol_r = st_d.vol_r;
            end
        endcase

        // Times hold for normal rate; with double rate the analog side
        // scales them, so the encoded figures are passed on unchanged
        st_d.noise_l = noise_dbc(st_d.dbc_l[7:3]);
        st_d.noise_r = noise_dbc(st_d.dbc_r[7:3]);
        st_d.sig_l = sig_dbc(st_d.dbc_l[2:0]);
        st_d.sig_r = sig_dbc(st_d.dbc_r[2:0]);
        st_d.pwron = pwron_delay(st_d.pop[7:4]);
        // Kept as a register so the output comes straight from a flop
        st_d.ramp = (st_d.pop[3:2] == 2'b11) ? 3'h4
                                             : {1'b0, st_d.pop[3:2]};
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            st_q <= '0;
            st_q.vol_l <= `CDR_RST_DAC_VOL;
            st_q.vol_r <= `CDR_RST_DAC_VOL;
            st_q.eff_vol_l <= `CDR_RST_DAC_VOL;
            st_q.eff_vol_r <= `CDR_RST_DAC_VOL;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.ack = st_q.ack;
    assign link.rdata = st_q.rdata;
    assign DAC_PWR_L = st_q.dac_pwr[7];
    assign DAC_PWR_R = st_q.dac_pwr[6];
    assign LEFT_COMMON_DRV_CFG = st_q.dac_pwr[5:4];
    assign RIGHT_COMMON_DRV_CFG = st_q.hp_drv[5:3];
    assign SCP_EN = st_q.hp_drv[2];
    assign SCP_AUTO_PD = st_q.hp_drv[1];
    assign COMMON_MODE_VOLTAGE_SEL = st_q.out_stage[7:6];
    assign BYPASS_L = st_q.out_stage[5:4];
    assign BYPASS_R = st_q.out_stage[3:2];
    assign SOFT_STEP = st_q.out_stage[1:0];
    assign DAC_SWITCH_L = st_q.dac_sw[7:6];
    assign DAC_SWITCH_R = st_q.dac_sw[5:4];
    assign PWRON_DELAY_10US = st_q.pwron;
    assign RAMP_STEP_MS = st_q.ramp;
    assign WEAK_CM_BANDGAP = st_q.pop[1];
    assign MUTE_L = st_q.eff_vol_l[7];
    assign MUTE_R = st_q.eff_vol_r[7];
    assign ATTEN_L = st_q.eff_vol_l[6:0];
    assign ATTEN_R = st_q.eff_vol_r[6:0];
    assign NOISE_DBC_HALF_MS_L = st_q.noise_l;
    assign NOISE_DBC_HALF_MS_R = st_q.noise_r;
    assign SIG_DBC_HALF_MS_L = st_q.sig_l;
    assign SIG_DBC_HALF_MS_R = st_q.sig_r;
endmodule

// ==== cdr_host_ctrl.sv ====
// Host controller: takes register orders from software over AXI4-Lite and
// runs one access at a time on the codec register link.
// Assumes the device answers every request with a one-cycle ack.
`timescale 1ns/1ps
`include "cdr_consts.svh"

module cdr_host_ctrl (
    input wire logic MCLK,
    input wire logic RST_B,
    cdr_link_if.host link,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import cdr_pkg::*;

    cdr_host_st_t st_q;
    cdr_host_st_t st_d;
    logic busy;

    assign busy = (st_q.state == CDR_H_WAIT);

    always_comb begin
        st_d = st_q;

        if (S_AXI_AWVALID && st_q.aw_rdy) begin
            st_d.aw_got = 1'b1;
            st_d.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && st_q.w_rdy) begin
            st_d.w_got = 1'b1;
            st_d.w_data = S_AXI_WDATA;
            st_d.w_strb = S_AXI_WSTRB;
        end
        if (st_q.bvld && S_AXI_BREADY) begin
            st_d.bvld = 1'b0;
        end

        unique case (st_q.state)
            CDR_H_IDLE: begin
                if (st_q.req) begin
                    st_d.state = CDR_H_WAIT;
                end
            end
            CDR_H_WAIT: begin
                if (link.ack) begin
                    st_d.req = 1'b0;
                    st_d.rdata = link.rdata;
                    st_d.state = CDR_H_IDLE;
                end
            end
        endcase

        // Both halves of a write present: commit and answer
        if (st_q.aw_got && st_q.w_got && !st_q.bvld) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvld = 1'b1;
            st_d.bresp = `CDR_AXI_OKAY;
            if (st_q.aw_addr == `CDR_AXI_CMD) begin
                if (st_q.w_strb[0]) begin
                    st_d.cmd_addr = st_q.w_data[7:0];
                end
                if (st_q.w_strb[1]) begin
                    st_d.cmd_data = st_q.w_data[15:8];
                end
                if (st_q.w_strb[2]) begin
                    st_d.cmd_we = st_q.w_data[`CDR_CMD_WRITE_BIT];
                end
                // An order arriving while busy updates the command fields but is not started
                if (!busy && !st_q.req && st_q.w_strb[2]) begin
                    st_d.req = 1'b1;
                    st_d.we = st_q.w_data[`CDR_CMD_WRITE_BIT];
                    st_d.addr = st_q.w_strb[0] ? st_q.w_data[7:0]
                                               : st_q.cmd_addr;
                    st_d.wdata = st_q.w_strb[1] ? st_q.w_data[15:8]
                                                : st_q.cmd_data;
                end
            end else if (st_q.aw_addr == `CDR_AXI_STATUS) begin
                if (st_q.w_strb[0] && st_q.w_data[`CDR_STS_DONE_BIT]) begin
                    st_d.done = 1'b0;
                end
            end else begin
                st_d.bresp = `CDR_AXI_SLVERR;
            end
        end

        // Completion sets done after any clear, so the set wins
        if (busy && link.ack) begin
            st_d.done = 1'b1;
        end

        if (st_q.rvld && S_AXI_RREADY) begin
            st_d.rvld = 1'b0;
        end
        if (S_AXI_ARVALID && st_q.ar_rdy) begin
            st_d.rvld = 1'b1;
            st_d.rresp = `CDR_AXI_OKAY;
            if (S_AXI_ARADDR == `CDR_AXI_CMD) begin
                st_d.rd = {15'h0000, st_q.cmd_we, st_q.cmd_data,
                           st_q.cmd_addr};
            end else if (S_AXI_ARADDR == `CDR_AXI_STATUS) begin
                st_d.rd = {16'h0000, st_q.rdata, 6'h00, st_q.done,
                           busy || st_q.req};
            end else begin
                st_d.rd = 32'h0000_0000;
                st_d.rresp = `CDR_AXI_SLVERR;
            end
        end

        st_d.aw_rdy = !st_d.aw_got && !st_d.bvld;
        st_d.w_rdy = !st_d.w_got && !st_d.bvld;
        st_d.ar_rdy = !st_d.rvld;
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            st_q <= '0;
            st_q.state <= CDR_H_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.req = st_q.req;
    assign link.we = st_q.we;
    assign link.addr = st_q.addr;
    assign link.wdata = st_q.wdata;
    assign S_AXI_AWREADY = st_q.aw_rdy;
    assign S_AXI_WREADY = st_q.w_rdy;
    assign S_AXI_BRESP = st_q.bresp;
    assign S_AXI_BVALID = st_q.bvld;
    assign S_AXI_ARREADY = st_q.ar_rdy;
    assign S_AXI_RDATA = st_q.rd;
    assign S_AXI_RRESP = st_q.rresp;
    assign S_AXI_RVALID = st_q.rvld;
endmodule

// ==== cdr_link_props.sv ====
// Checker for the register link between host controller and register slice.
// Takes the link signals as plain inputs; one clock, synchronous reset.
`timescale 1ns/1ps
module cdr_link_props (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // A read request that the slice will take on this edge
    wire rd_t = req && !we && !ack;

    ack_pulse_a: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (req && !ack |=> ack)
        else $error("request not answered next cycle");
    ack_cause_a: assert property (ack |-> $past(req))
        else $error("ack without request");
    // Skip the first edge after reset, which still sees pre-reset data
    rdata_hold_a: assert property (
        !ack && $past(RST_B) |-> $stable(rdata))
        else $error("read data moved without a read");
    rsvd_reg_a: assert property (
        rd_t && addr == 8'h27 |=> rdata == 8'h00)
        else $error("reserved register read nonzero");
    pwr_rsvd_a: assert property (
        rd_t && addr == 8'h25 |=> !(|rdata[3:0]))
        else $error("power register reserved bits set");
    drv_rsvd_a: assert property (
        rd_t && addr == 8'h26 |=> (rdata & 8'hc1) == 8'h00)
        else $error("driver register reserved bits set");
    sw_rsvd_a: assert property (
        rd_t && addr == 8'h29 |=> !(|rdata[3:2]))
        else $error("switch register reserved bits set");
    pop_rsvd_a: assert property (rd_t && addr == 8'h2a |=> !rdata[0])
        else $error("pop register reserved bit set");
    unmapped_a: assert property (
        rd_t && addr > 8'h2c |=> rdata == 8'h00)
        else $error("unmapped read nonzero");
endmodule

// ==== testbench.sv ====
// Self-checking bench: software view over AXI4-Lite, link checked by props.
// Assumes the host controller command and status layout of the consts file.
`timescale 1ns/1ps
`include "cdr_consts.svh"
module testbench;
    logic MCLK, RST_B, PGA_MATCH_L, PGA_MATCH_R, ADC_UP_L, ADC_UP_R;
    logic BELOW_NOISE_L, BELOW_NOISE_R, DOUBLE_RATE_AUDIO;
    logic DAC_PWR_L, DAC_PWR_R;
    logic SCP_EN, SCP_AUTO_PD, WEAK_CM_BANDGAP, MUTE_L, MUTE_R;
    logic [7:0] AGC_GAIN_L, AGC_GAIN_R, S_AXI_AWADDR, S_AXI_ARADDR, v;
    logic [6:0] AGC_MAX_L, AGC_MAX_R, ATTEN_L, ATTEN_R;
    logic [6:0] SIG_DBC_HALF_MS_L, SIG_DBC_HALF_MS_R;
    logic [1:0] LEFT_COMMON_DRV_CFG, COMMON_MODE_VOLTAGE_SEL;
    logic [1:0] BYPASS_L, BYPASS_R, SOFT_STEP, DAC_SWITCH_L, DAC_SWITCH_R;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [2:0] RIGHT_COMMON_DRV_CFG, RAMP_STEP_MS;
    logic [18:0] PWRON_DELAY_10US;
    logic [11:0] NOISE_DBC_HALF_MS_L, NOISE_DBC_HALF_MS_R;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, s;
    logic [3:0] S_AXI_WSTRB;
    logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, S_AXI_RREADY;
    logic [1:0] r;
    int error_cnt = 0;
    int samples_checked = 0;
    // Legal values only: reserved bits zero and no reserved codes
    logic [7:0] mk [13] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'he0, 8'h26,
        8'h00, 8'hfe, 8'ha3, 8'hbe, 8'hff, 8'hff};
    int dly [12] = '{0, 1, 10, 100, 1000, 5000, 10000, 20000, 40000, 80000,
        200000, 400000};

    cdr_link_if link();
    cdr_dev_regs cdr_dev_regs_inst (.*);
    cdr_host_ctrl cdr_host_ctrl_inst (.*);
    cdr_link_props cdr_link_props_inst (.MCLK(MCLK), .RST_B(RST_B),
        .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
        .ack(link.ack), .rdata(link.rdata));

    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge MCLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge MCLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge MCLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        s = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask

    // One link access through the command register; done is then cleared
    task automatic dev(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        axi_wr(`CDR_AXI_CMD, {15'h0, w, d, a});
        do axi_rd(`CDR_AXI_STATUS); while (s[1] !== 1'b1);
        v = s[15:8];
        axi_wr(`CDR_AXI_STATUS, 32'h2);
    endtask

    function automatic int dbn(input int c);
        return c == 0 ? 0 : (c < 8 ? 1 << (c - 1) : 128 * (c - 7));
    endfunction

    initial begin
        #100000;
        error_cnt++;
        complete_run;
    end

    initial begin
        {RST_B, PGA_MATCH_L, PGA_MATCH_R, ADC_UP_L, ADC_UP_R} = 5'h0;
        {BELOW_NOISE_L, BELOW_NOISE_R, DOUBLE_RATE_AUDIO} = 3'h0;
        {AGC_GAIN_L, AGC_GAIN_R} = 16'h0;
        {AGC_MAX_L, AGC_MAX_R} = {7'h77, 7'h77};
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
        {S_AXI_WSTRB, S_AXI_AWVALID, S_AXI_WVALID} = 6'h3c;
        {S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 3'h0;
        repeat (6) @(posedge MCLK);
        RST_B <= 1'b1;
        for (int a = 0; a < 13; a++) begin
            dev(1'b0, 8'h20 + a, 8'h00);
            chk(v, a > 10 ? 8'h80 : 8'h00);
        end
        $display("test reset values done");
        for (int a = 0; a < 13; a++) begin
            if (a != 7) dev(1'b1, 8'h20 + a, mk[a]);
        end
        for (int a = 0; a < 13; a++) begin
            dev(1'b0, 8'h20 + a, 8'h00);
            chk(v, (a < 2 || a == 4) ? 8'h00 : mk[a]);
        end
        chk({DAC_PWR_L, DAC_PWR_R, SCP_EN, SCP_AUTO_PD}, 4'hf);
        chk({WEAK_CM_BANDGAP, MUTE_L, ATTEN_L}, 9'h1ff);
        chk({COMMON_MODE_VOLTAGE_SEL, BYPASS_L, BYPASS_R}, 6'h3f);
        chk({LEFT_COMMON_DRV_CFG, RIGHT_COMMON_DRV_CFG}, 5'h14);
        chk({SOFT_STEP, DAC_SWITCH_L, DAC_SWITCH_R}, 6'h2a);
        $display("test write masks done");
        for (int c = 0; c < 32; c++) begin
            @(posedge MCLK) DOUBLE_RATE_AUDIO <= c[0];
            dev(1'b1, 8'h22, {c[4:0], c[2:0]});
            dev(1'b1, 8'h23, {5'd31 - c[4:0], ~c[2:0]});
            chk(NOISE_DBC_HALF_MS_L, dbn(c));
            chk(SIG_DBC_HALF_MS_L, dbn(c % 8));
            chk(NOISE_DBC_HALF_MS_R, dbn(31 - c));
            chk(SIG_DBC_HALF_MS_R, dbn(7 - c % 8));
        end
        $display("test debounce done");
        for (int c = 0; c < 12; c++) begin
            dev(1'b1, 8'h2a, {c[3:0], c[1:0], 2'b10});
            chk(PWRON_DELAY_10US, dly[c]);
            chk(RAMP_STEP_MS, c % 4 == 3 ? 4 : c % 4);
            chk(WEAK_CM_BANDGAP, 1'b1);
        end
        $display("test pop reduction done");
        dev(1'b1, 8'h2b, 8'h05);
        dev(1'b1, 8'h2c, 8'h8a);
        for (int k = 0; k < 4; k++) begin
            dev(1'b1, 8'h29, 8'h0 + k);
            chk({MUTE_L, ATTEN_L}, k == 1 ? 8'h8a : 8'h05);
            chk({MUTE_R, ATTEN_R}, k == 2 ? 8'h05 : 8'h8a);
        end
        $display("test volume linkage done");
        @(posedge MCLK);
        {PGA_MATCH_L, ADC_UP_L, ADC_UP_R, BELOW_NOISE_R} <= 4'hf;
        {AGC_GAIN_L, AGC_MAX_L, AGC_GAIN_R, AGC_MAX_R} <= {8'h10, 7'h10,
            8'h77, 7'h7f};
        for (int k = 0; k < 2; k++) begin
            dev(1'b0, 8'h24, 8'h00);
            chk(v, k ? 8'h7d : 8'hd7);
            dev(1'b1, 8'h24, 8'h00);
            {PGA_MATCH_L, PGA_MATCH_R, BELOW_NOISE_L, BELOW_NOISE_R} <= 4'h6;
        end
        dev(1'b0, 8'h20, 8'h00);
        chk(v, 8'h10);
        AGC_GAIN_L <= 8'he8;
        dev(1'b0, 8'h20, 8'h00);
        chk(v, 8'he8);
        dev(1'b0, 8'h21, 8'h00);
        chk(v, 8'h77);
        dev(1'b0, 8'h30, 8'h00);
        chk(v, 8'h00);
        axi_rd(8'h08);
        chk(r, `CDR_AXI_SLVERR);
        axi_wr(8'h0c, 32'h0);
        chk(r, `CDR_AXI_SLVERR);
        $display("test status flags done");
        complete_run;
    end
endmodule
